// >>> core/pew_ctrl.sv
// host-side controller driving a byte-wide parallel eeprom
// Summary of operation
// RULE1: write cycle is a strobe low pulse with chip select low and output gate high.
// RULE2: device latches address on the later falling strobe edge.
// RULE3: device latches data on the first rising strobe edge.
// RULE4: device times programming itself once a write starts.
// RULE5: reads during programming return polling status.
// RULE6: a page write commits 1 to 64 bytes in one programming period.
// RULE7: host loads each next page byte within the byte load window.
// RULE8: window expiry ends loading and starts programming.
// RULE9: host keeps page select lines constant across one page load.
// RULE10: byte select lines pick the byte; any order, reload allowed.
// RULE11: only loaded bytes are programmed.
// RULE12: during programming poll line reads inverted bit 7 of last byte.
// RULE13: during programming flip line inverts on each read.
// RULE14: no write starts with gate low, select high or strobe high.
// RULE15: strobe pulses under 15 ns start no write.
// RULE16: writes blocked for 5 ms after power valid.
// RULE17: three-write sequence sets the lock after program cycle time.
// RULE18: with lock set, the enable prefix before data still writes.
// RULE19: lock survives power cycles, cleared by disable sequence.
// RULE20: host issues lock sequences with page load timing.
// RULE21: command data bytes are not stored in the array.
// RULE22: locked write without prefix starts timer, stores nothing.
// RULE23: high voltage on id select reaches 64 id bytes at 1FC0-1FFF.
// RULE24: device drives data on read, floats when select or gate high; the model drives the inverse of its last read value instead.
// RULE25: enable command is AA@1555, 55@0AAA, A0@1555 in one load.
// RULE26: lock commands take effect at end of write period.
// RULE27: host starts no new write until polling shows completion.
`timescale 1ns/1ps
`default_nettype none
module pew_ctrl
  import pew_pkg::*;
#(
  parameter int BLC_CYCLES = pew_pkg::BLC_CYC,
  parameter int PWR_CYCLES = pew_pkg::PWR_CYC
)(
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  // user command port
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire pew_pkg::pew_op_t           req_op,
  input  wire logic [pew_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [pew_pkg::DATA_W-1:0] req_data,
  input  wire logic                       req_last,
  input  wire logic                       req_protect,
  input  wire logic                       req_id_area,
  output logic                            rsp_valid,
  output logic [pew_pkg::DATA_W-1:0]      rsp_data,
  output logic                            busy,
  output logic                            load_open,
  // device pins
  output logic [pew_pkg::ADDR_W-1:0]      mem_addr,
  input  wire logic [pew_pkg::DATA_W-1:0] mem_data_i,
  output logic [pew_pkg::DATA_W-1:0]      mem_data_o,
  output logic                            mem_data_oe,
  output logic                            chip_select_n,
  output logic                            output_gate_n,
  output logic                            write_strobe_n,
  output logic                            id_area_select_line
);
  import pew_pkg::*;

  initial
  begin
    if (BLC_CYCLES < WP_CYC + WPH_CYC + 8 || BLC_CYCLES >= (1 << CNT_W) || PWR_CYCLES < 1 ||
        PWR_CYCLES >= (1 << CNT_W))
      $error("pew_ctrl: timing parameter out of range");
  end

  typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_READ, ST_POLL, ST_GAP} pew_st_t;

  typedef struct packed {
    pew_st_t                  st;
    logic [CNT_W-1:0]         cnt;
    logic [CNT_W-1:0]         win;
    logic                     loading;
    logic                     polling;
    logic                     seen;
    logic [1:0]               seq;
    logic [1:0]               seq_len;
    logic                     seq_pend;
    pew_op_t                  op;
    logic                     last;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W-1:0]        data;
    logic [ADDR_W-1:0]        poll_addr;
    logic [DATA_W-1:0]        poll_data;
    logic [DATA_W-1:0]        prev;
    logic                     ce_n;
    logic                     oe_n;
    logic                     we_n;
    logic                     doe;
    logic                     id_sel;
    logic                     rsp;
    logic [DATA_W-1:0]        rdata;
  } pew_state_t;

  pew_state_t s_q;
  pew_state_t s_d;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // command bytes for lock enable and disable prefixes
  function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(input pew_op_t op, input logic [2:0] i);
    case (i)
      3'd0:    cmd_word = {CMD_A0, CMD_D0};
      3'd1:    cmd_word = {CMD_A1, CMD_D1};
      3'd2:    cmd_word = {CMD_A0, (op == PEW_OP_UNLOCK) ? CMD_DIS1 : CMD_EN};
      3'd3:    cmd_word = {CMD_A0, CMD_DIS2};
      3'd4:    cmd_word = {CMD_A1, CMD_DIS3};
      default: cmd_word = {CMD_A0, CMD_DIS};
    endcase
  endfunction

  logic [2:0] seq_idx;

  always_comb
  begin
    s_d = s_q;
    seq_idx = 3'(s_q.seq);
    if (s_q.op == PEW_OP_UNLOCK && s_q.seq_len == 2'd0)
      seq_idx = 3'(s_q.seq) + 3'd3;
    s_d.rsp = 1'b0;
    if (s_q.loading && s_q.st != ST_LOW && s_q.st != ST_HIGH)
    begin
      // window runs from last load; expiry hands the page to the device
      if (s_q.win == '0)
      begin
        s_d.loading = 1'b0; // RULE8
        s_d.polling = 1'b1; // RULE4
        s_d.prev = '0;
        s_d.seen = 1'b0;
      end
      else
        s_d.win = s_q.win - 1'b1;
    end
    case (s_q.st)
      ST_PWR:
      begin
        if (s_q.cnt == '0)
          s_d.st = ST_IDLE;
        else
          s_d.cnt = s_q.cnt - 1'b1; // RULE16
      end
      ST_IDLE:
      begin
        if (s_q.seq_pend)
        begin
          {s_d.addr, s_d.data} = cmd_word(s_q.op, seq_idx); // RULE25 RULE20
          s_d.st = ST_SETUP;
          s_d.cnt = '0;
        end
        else if (req_valid && !s_q.polling && !(s_q.loading && req_op == PEW_OP_READ) &&
                 !(s_q.loading && s_q.win == '0))
        begin
          // RULE27
          s_d.op = req_op;
          s_d.addr = req_addr;
          s_d.data = req_data;
          s_d.last = req_last;
          s_d.id_sel = req_id_area; // RULE23
          s_d.cnt = '0;
          s_d.seq = '0;
          if (req_op == PEW_OP_READ)
            s_d.st = ST_READ;
          else if (req_op == PEW_OP_WRITE && !(req_protect && !s_q.loading))
            s_d.st = ST_SETUP;
          else
          begin
            // prefix only at the start of a load, then user data follows
            // user byte waits in the poll registers while the prefix goes out
            s_d.poll_addr = req_addr;
            s_d.poll_data = req_data;
            s_d.seq_pend = 1'b1; // RULE18
            s_d.seq_len = (req_op == PEW_OP_UNLOCK) ? 2'd3 : 2'd0;
            if (req_op != PEW_OP_WRITE)
              s_d.last = 1'b1;
            s_d.op = req_op;
          end
        end
      end
      ST_SETUP:
      begin
        // gate high and address stable before the strobe falls
        s_d.ce_n = 1'b0; // RULE1
        s_d.oe_n = 1'b1; // RULE14
        s_d.doe = 1'b1;
        s_d.st = ST_LOW;
        // strobe stays low for exactly WP_CYC cycles
        s_d.cnt = CNT_W'(WP_CYC);
      end
      ST_LOW:
      begin
        s_d.we_n = 1'b0; // RULE2
        if (s_q.cnt == '0)
        begin
          s_d.we_n = 1'b1; // RULE3
          s_d.st = ST_HIGH;
          s_d.cnt = cyc(WPH_CYC);
        end
        else
          s_d.cnt = s_q.cnt - 1'b1; // RULE15
      end
      ST_HIGH:
      begin
        s_d.ce_n = 1'b1;
        if (s_q.cnt == '0)
        begin
          s_d.doe = 1'b0;
          s_d.st = ST_IDLE;
          s_d.loading = 1'b1; // RULE6
          // closes early so a byte taken on the last window cycle still latches in time
          s_d.win = CNT_W'(BLC_CYCLES - WP_CYC - WPH_CYC - 4); // RULE7
          if (!s_q.seq_pend || s_q.op != PEW_OP_WRITE)
          begin
            s_d.poll_addr = s_q.addr; // RULE9
            s_d.poll_data = s_q.data;
          end
          if (s_q.seq_pend)
          begin
            if (s_q.seq == 2'd2 && (s_q.seq_len == 2'd0 || s_q.op != PEW_OP_UNLOCK))
              s_d.seq_pend = 1'b0;
            else if (s_q.seq == 2'd2)
            begin
              s_d.seq = '0;
              s_d.seq_len = 2'd0;
            end
            else
              s_d.seq = s_q.seq + 2'd1;
            if (s_q.seq == 2'd2 && s_q.seq_len == 2'd0 && s_q.op == PEW_OP_WRITE)
            begin
              // prefix done; user byte now goes out
              s_d.st = ST_SETUP;
              s_d.addr = s_q.poll_addr;
              s_d.data = s_q.poll_data;
            end
          end
          if (s_q.last && !s_d.seq_pend && s_d.st == ST_IDLE)
          begin
            s_d.loading = 1'b0; // RULE26
            s_d.polling = 1'b1;
            s_d.prev = '0;
            s_d.seen = 1'b0;
            s_d.rsp = 1'b1;
          end
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      ST_READ, ST_POLL:
      begin
        s_d.ce_n = 1'b0;
        s_d.oe_n = 1'b0; // RULE24
        s_d.doe = 1'b0;
        if (s_q.cnt == cyc(ACC_CYC))
        begin
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.cnt = '0;
          if (s_q.st == ST_READ)
          begin
            s_d.rdata = mem_data_i;
            s_d.rsp = 1'b1;
            s_d.st = ST_IDLE;
          end
          else
          begin
            s_d.prev = mem_data_i;
            s_d.seen = 1'b1;
            s_d.st = ST_GAP;
            // done when bit 7 true and bit 6 stopped flipping
            if (mem_data_i[POLL_BIT] == s_q.poll_data[POLL_BIT] && // RULE12
                mem_data_i[FLIP_BIT] == s_q.prev[FLIP_BIT] && // RULE13
                s_q.seen)
              s_d.polling = 1'b0; // RULE5
          end
        end
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      ST_GAP:
      begin
        if (s_q.cnt == cyc(ACC_CYC))
        begin
          s_d.st = ST_IDLE;
          s_d.cnt = '0;
        end
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // polling runs on its own whenever the device is programming
    if (s_d.st == ST_IDLE && s_d.polling && !s_d.seq_pend && s_q.st != ST_GAP)
    begin
      s_d.st = ST_POLL;
      s_d.addr = s_d.poll_addr;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.st <= ST_PWR;
      s_q.cnt <= CNT_W'(PWR_CYCLES - 1);
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // RULE10 RULE11 RULE21 RULE22 RULE17 RULE19 RULE20: device-side, host keeps timing
  assign req_ready           = s_q.st == ST_IDLE && !s_q.seq_pend && !s_q.polling &&
                               !(s_q.loading && req_op == PEW_OP_READ) && !(s_q.loading && s_q.win == '0);
  assign rsp_valid           = s_q.rsp;
  assign rsp_data            = s_q.rdata;
  assign busy                = s_q.polling || s_q.st == ST_PWR;
  assign load_open           = s_q.loading;
  assign mem_addr            = s_q.addr;
  assign mem_data_o          = s_q.data;
  assign mem_data_oe         = s_q.doe;
  assign chip_select_n       = s_q.ce_n;
  assign output_gate_n       = s_q.oe_n;
  assign write_strobe_n      = s_q.we_n;
  assign id_area_select_line = s_q.id_sel;
endmodule
`default_nettype wire

// >>> core/pew_pkg.sv
// package: constants for the parallel eeprom write controller (host side)
package pew_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam int          ADDR_W           = 13;
  localparam int          DATA_W           = 8;
  localparam int          PAGE_BYTES       = 64;
  localparam int          BYTE_SEL_W       = 6;
  // write pulse: low 100 ns min, high 50 ns min
  localparam int          T_WP_NS          = 100;
  localparam int          T_WPH_NS         = 50;
  localparam int          WP_CYC           = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int          WPH_CYC          = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  // read access: oe to output 150 ns worst
  localparam int          T_ACC_NS         = 150;
  localparam int          ACC_CYC          = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  // byte load window 150 us (longest, round down)
  localparam int          T_BLC_US         = 150;
  localparam int          BLC_CYC          = T_BLC_US * CLK_MHZ;
  // power-on write delay 5 ms
  localparam int          T_PWR_MS         = 5;
  localparam int          PWR_CYC          = T_PWR_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W            = 24;
  localparam logic [12:0] CMD_A0           = 13'h1555;
  localparam logic [12:0] CMD_A1           = 13'h0AAA;
  localparam logic [7:0]  CMD_D0           = 8'hAA;
  localparam logic [7:0]  CMD_D1           = 8'h55;
  localparam logic [7:0]  CMD_EN           = 8'hA0;
  localparam logic [7:0]  CMD_DIS          = 8'h20;
  localparam logic [7:0]  CMD_DIS1         = 8'h80;
  localparam logic [7:0]  CMD_DIS2         = 8'hAA;
  localparam logic [7:0]  CMD_DIS3         = 8'h55;
  localparam logic [12:0] ID_BASE          = 13'h1FC0;
  localparam int          POLL_BIT         = 7;
  localparam int          FLIP_BIT         = 6;
  typedef enum logic [1:0] {PEW_OP_WRITE, PEW_OP_READ, PEW_OP_LOCK, PEW_OP_UNLOCK} pew_op_t;
endpackage

// >>> sim/pew_ctrl_checker.sv
// pin-level assertions for the eeprom write controller
`timescale 1ns/1ps
`default_nettype none
module pew_ctrl_checker
  import pew_pkg::*;
#(
  parameter int BLC_CYCLES = 200,
  parameter int PWR_CYCLES = 10
)(
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic                       req_ready,
  input  wire logic                       busy,
  input  wire logic                       load_open,
  input  wire logic [pew_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [pew_pkg::DATA_W-1:0] mem_data_o,
  input  wire logic                       mem_data_oe,
  input  wire logic                       chip_select_n,
  input  wire logic                       output_gate_n,
  input  wire logic                       write_strobe_n
);
  import pew_pkg::*;
  int lo_q;
  int idle_q;
  int pw_q;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      lo_q   <= 0;
      idle_q <= 0;
      pw_q   <= 0;
    end
    else
    begin
      lo_q   <= write_strobe_n ? 0 : lo_q + 1;
      idle_q <= (load_open && write_strobe_n) ? idle_q + 1 : 0;
      pw_q   <= (pw_q < PWR_CYCLES) ? pw_q + 1 : pw_q;
    end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_cs; !write_strobe_n |-> !chip_select_n; endproperty
  a_cs: assert property (p_cs) else $error("strobe without select");
  property p_gate; !write_strobe_n |-> output_gate_n && mem_data_oe; endproperty
  a_gate: assert property (p_gate) else $error("strobe with gate low");
  property p_addr; !write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in strobe");
  property p_data; !write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_data_o); endproperty
  a_data: assert property (p_data) else $error("data moved in strobe");
  property p_width; $rose(write_strobe_n) |-> lo_q >= WP_CYC; endproperty
  a_width: assert property (p_width) else $error("strobe too short");
  property p_read; !output_gate_n |-> write_strobe_n && !mem_data_oe; endproperty
  a_read: assert property (p_read) else $error("bus contention on read");
  property p_hold; $fell(output_gate_n) |-> !output_gate_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("read gate too short");
  property p_ready; busy |-> !req_ready; endproperty
  a_ready: assert property (p_ready) else $error("accepted while polling");
  property p_pwr; req_ready |-> pw_q >= PWR_CYCLES - 1; endproperty
  a_pwr: assert property (p_pwr) else $error("ready before power delay");
  property p_win; idle_q <= BLC_CYCLES + 2; endproperty
  a_win: assert property (p_win) else $error("load window overrun");
  c_load: cover property ($rose(write_strobe_n) ##[1:30] $rose(load_open));
  c_poll: cover property ($fell(output_gate_n) && busy);
  c_page: cover property (load_open ##1 !write_strobe_n);
endmodule
bind pew_ctrl pew_ctrl_checker #(.BLC_CYCLES(BLC_CYCLES), .PWR_CYCLES(PWR_CYCLES)) u_chk (.clock, .rst_b,
  .req_ready, .busy, .load_open, .mem_addr, .mem_data_o, .mem_data_oe, .chip_select_n, .output_gate_n,
  .write_strobe_n);
`default_nettype wire

// >>> sim/pew_eeprom_model.sv
// behavioural model of the parallel eeprom
`timescale 1ns/1ps
`default_nettype none
module pew_eeprom_model
  import pew_pkg::*;
#(
  parameter int BLC  = 200,
  parameter int PWR  = 10,
  parameter int PROG = 400
)(
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic [pew_pkg::ADDR_W-1:0] addr,
  input  wire logic [pew_pkg::DATA_W-1:0] bus,
  input  wire logic                       chip_select_n,
  input  wire logic                       output_gate_n,
  input  wire logic                       write_strobe_n,
  input  wire logic                       id_area_select_line,
  output logic [pew_pkg::DATA_W-1:0]      dq
);
  import pew_pkg::*;
  localparam logic [20:0] SQ [5] = '{{CMD_A0, CMD_D0}, {CMD_A1, CMD_D1}, {CMD_A0, CMD_DIS1},
    {CMD_A0, CMD_DIS2}, {CMD_A1, CMD_DIS3}};
  logic [7:0]  mem [0:8255];
  logic [21:0] q [$];
  logic [13:0] a_l;
  logic [7:0]  last;
  logic [7:0]  rel;
  logic        lock = 1'b0;
  logic        lock_d = 1'b0;
  logic        tog = 1'b0;
  logic        arm;
  logic        rd_seen;
  int          win;
  int          prog;
  int          pw;
  int          pre;
  realtime     t_f;
  wire logic   wr_n = chip_select_n | write_strobe_n;
  wire logic   rd_n = chip_select_n | output_gate_n;
  function automatic int ix(input logic [13:0] a);
    return a[13] ? 8192 + a[5:0] : a[12:0];
  endfunction
  function automatic logic seq(input int n, input logic [7:0] d);
    logic ok;
    ok = q.size() >= n && q[n-1][20:0] == {CMD_A0, d};
    for (int i = 0; i < n - 1; i++)
      ok = ok && q[i][20:0] == SQ[i];
    return ok;
  endfunction
  initial
    foreach (mem[i])
      mem[i] = 8'hFF;
  always @(negedge wr_n)
  begin
    arm = output_gate_n && pw >= PWR && prog == 0;
    a_l = {id_area_select_line, addr};
    t_f = $realtime;
  end
  always @(posedge wr_n)
    if (arm && output_gate_n && $realtime - t_f >= 15.0)
    begin
      q.push_back({a_l, bus});
      win = 0;
      arm = 0;
    end
  // a read ends the load at once, as real parts do
  always @(negedge rd_n)
  begin
    if (prog > 0)
      tog = ~tog;
    if (q.size() > 0)
      rd_seen = 1;
  end
  wire logic       drv = !rd_n && write_strobe_n;
  wire logic [7:0] rv = prog > 0 ? {~last[7], tog, last[5:0]} : mem[ix({id_area_select_line, addr})];
  assign dq = drv ? rv : rel;
  // released bus shows the inverse so a stale value is never read as good
  always @(posedge clock)
    if (drv)
      rel <= ~rv;
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      pw = 0;
      prog = 0;
      rd_seen = 0;
      q.delete();
    end
    else
    begin
      pw = pw + (pw < PWR);
      if (prog > 0)
        prog--;
      if (prog == 0)
        lock = lock_d;
      win++;
      if (q.size() > 0 && (rd_seen || win > BLC))
      begin
        pre = seq(3, CMD_EN) ? 3 : seq(6, CMD_DIS) ? 6 : 0;
        lock_d = pre == 3 ? 1'b1 : pre == 6 ? 1'b0 : lock;
        if (!lock || pre > 0)
          for (int i = pre; i < q.size(); i++)
            mem[ix(q[i][21:8])] = q[i][7:0];
        last = q[q.size()-1][7:0];
        prog = PROG;
        q.delete();
        rd_seen = 0;
      end
    end
endmodule
`default_nettype wire

// >>> sim/parallel_eeprom_write_control_tb_top.sv
// testbench: controller against the eeprom model
`timescale 1ns/1ps
`default_nettype none
`define PEW_CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module parallel_eeprom_write_control_tb_top;
  import pew_pkg::*;
  localparam int BLC = 200;
  localparam int PWR = 10;
  logic        clock, rst_b, req_valid, req_last, req_protect, req_id_area;
  pew_op_t     req_op;
  logic [12:0] req_addr, a;
  logic [7:0]  req_data, e, sh [0:8255], exp_q [$];
  logic [5:0]  offs [4] = '{6'h05, 6'h02, 6'h05, 6'h3F};
  int          fails, n_tests, pg;
  wire logic   req_ready, rsp_valid, busy, load_open, mem_data_oe;
  wire logic   chip_select_n, output_gate_n, write_strobe_n, id_area_select_line;
  wire logic [7:0]  rsp_data, mem_data_o, bus, dq;
  wire logic [12:0] mem_addr;
  assign bus = mem_data_oe ? mem_data_o : dq;
  pew_ctrl #(.BLC_CYCLES(BLC), .PWR_CYCLES(PWR)) dut (.clock, .rst_b, .req_valid, .req_ready, .req_op,
    .req_addr, .req_data, .req_last, .req_protect, .req_id_area, .rsp_valid, .rsp_data, .busy, .load_open,
    .mem_addr, .mem_data_i(bus), .mem_data_o, .mem_data_oe, .chip_select_n, .output_gate_n,
    .write_strobe_n, .id_area_select_line);
  pew_eeprom_model #(.BLC(BLC), .PWR(PWR)) u_mem (.clock, .rst_b, .addr(mem_addr), .bus, .chip_select_n,
    .output_gate_n, .write_strobe_n, .id_area_select_line, .dq);
  initial
  begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
    if (rsp_valid === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `PEW_CHK("rsp_data", e, rsp_data)
    end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic int ix(input logic [12:0] ad, input logic id);
    return id ? 8192 + ad[5:0] : ad;
  endfunction
  task automatic go(input pew_op_t op, input logic [12:0] ad, input logic [7:0] dt, input logic l = 1'b1,
    input logic p = 1'b0, input logic id = 1'b0);
    int k;
    @(negedge clock);
    {req_valid, req_addr, req_data, req_last, req_protect, req_id_area} = {1'b1, ad, dt, l, p, id};
    req_op = op;
    #1;
    for (k = 0; k < 50000 && req_ready !== 1'b1; k++)
      @(negedge clock);
    if (k == 50000)
    begin
      fails++;
      test_done();
    end
    @(negedge clock);
    req_valid = 0;
  endtask
  task automatic wr(input logic [12:0] ad, input logic [7:0] dt, input logic l, input logic st,
    input logic p = 1'b0, input logic id = 1'b0);
    go(PEW_OP_WRITE, ad, dt, l, p, id);
    if (st)
      sh[ix(ad, id)] = dt;
  endtask
  task automatic rd(input logic [12:0] ad, input logic id = 1'b0);
    int k;
    go(PEW_OP_READ, ad, 8'h00, 1'b1, 1'b0, id);
    exp_q.push_back(sh[ix(ad, id)]);
    for (k = 0; k < 2000 && exp_q.size() > 0; k++)
      @(negedge clock);
    if (k == 2000)
    begin
      fails++;
      test_done();
    end
  endtask
  initial
  begin
    {rst_b, req_valid, req_addr, req_data, req_last, req_protect, req_id_area} = '0;
    req_op = PEW_OP_WRITE;
    fails = 0;
    n_tests = 0;
    foreach (sh[i])
      sh[i] = 8'hFF;
    pg = $urandom(50834);
    repeat (8) @(negedge clock);
    rst_b = 1;
    @(negedge clock);
    `PEW_CHK("req_ready", 1'b0, req_ready)
    a = 13'($urandom_range(4095, 0));
    wr(a, 8'($urandom), 1'b1, 1'b1);
    rd(a);
    rd(a ^ 13'h0001);
    pg = $urandom_range(127, 0);
    foreach (offs[i])
      wr({pg[6:0], offs[i]}, 8'($urandom), i == 3, 1'b1);
    foreach (offs[i])
      rd({pg[6:0], offs[i]});
    rd({pg[6:0], 6'h07});
    wr(a + 13'h0040, 8'($urandom), 1'b0, 1'b1);
    rd(a + 13'h0040);
    a = ID_BASE | 13'($urandom_range(63, 0));
    wr(a, 8'h3C, 1'b1, 1'b1, 1'b0, 1'b1);
    rd(a, 1'b1);
    rd(a);
    go(PEW_OP_LOCK, 13'h0000, 8'h00);
    rd(CMD_A0);
    wr(13'h1100, 8'h91, 1'b1, 1'b0);
    rd(13'h1100);
    wr(CMD_A0, 8'h33, 1'b1, 1'b1, 1'b1);
    rd(CMD_A0);
    rst_b = 0;
    repeat (8) @(negedge clock);
    rst_b = 1;
    wr(13'h1100, 8'hA2, 1'b1, 1'b0);
    rd(13'h1100);
    go(PEW_OP_UNLOCK, 13'h0000, 8'h00);
    wr(13'h1100, 8'h44, 1'b1, 1'b1);
    rd(13'h1100);
    test_done();
  end
endmodule
`default_nettype wire
